// ===== rtl/asr_host.sv
/*
  Host controller for a 16K x 1 asynchronous static memory.
  Drives address, select, write strobe and data-in pins; samples data-out.
  Assumes the memory sits off-chip, so its data-out pin is synchronised
  by two flip-flops; the speed figures of the slowest grade are used.

*/
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_host
  import asr_pkg::*;
#(
  parameter int ADDR_W = `ASR_ADDR_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_rdata,
  output logic [ADDR_W-1:0] word_address,
  output logic sel_n,
  output logic we_n,
  output logic din,
  input wire logic dout
);
  // ----------------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------------
  logic dout_meta_q;
  logic dout_sync_q;

  // Two stages: the memory output is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_meta_q <= 1'b0;
      dout_sync_q <= 1'b0;
    end else begin
      dout_meta_q <= dout;
      dout_sync_q <= dout_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  asr_state_t state_q;
  asr_state_t state_d;
  logic write_q;
  logic [ADDR_W-1:0] addr_q;
  logic wdata_q;
  logic sel_n_q;
  logic we_n_q;
  logic ready_q;
  logic rsp_valid_q;
  logic rdata_q;
  asr_cnt_if cnt ();

  asr_timer u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cnt(cnt)
  );

  // Taken only while ready shows, so nothing is accepted right after reset
  wire take_req = (state_q == ASR_IDLE) && req_valid && ready_q;
  wire strobe_done = (state_q == ASR_STROBE) && cnt.done;
  // Write: lows last the full select count; strobes fall one cycle after load.
  // Read waits one extra cycle so synchronised data is past access time
  wire [3:0] strobe_len = req_write ? 4'(`ASR_WR_CYC)
                                    : 4'(`ASR_RD_CYC + 1);
  // Recovery lets the memory output float before the next request
  wire [3:0] recover_len = 4'(`ASR_FLOAT_CYC - 1);

  assign cnt.load = take_req || strobe_done;
  assign cnt.value = take_req ? strobe_len : recover_len;

  // Next-state decode
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ASR_IDLE: if (take_req) state_d = ASR_STROBE;
      ASR_STROBE: if (cnt.done) state_d = ASR_HOLD;
      ASR_HOLD: state_d = ASR_RECOVER;
      ASR_RECOVER: if (cnt.done) state_d = ASR_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ASR_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Address and data latched once; stable across the whole cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= '0;
      wdata_q <= 1'b0;
      write_q <= 1'b0;
    end else if (take_req) begin
      addr_q <= req_addr;
      wdata_q <= req_wdata;
      write_q <= req_write;
    end
  end

  // Strobes: select, and write strobe on writes only, fall one cycle after the address is set,
  // and rise together on leaving STROBE; address and data still hold.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_q <= 1'b1;
      we_n_q <= 1'b1;
    end else if (state_q == ASR_IDLE) begin
      sel_n_q <= 1'b1;
      we_n_q <= 1'b1;
    end else if (state_q == ASR_STROBE && !cnt.done) begin
      sel_n_q <= 1'b0;
      we_n_q <= !write_q;
    end else begin
      sel_n_q <= 1'b1;
      we_n_q <= 1'b1;
    end
  end

  // Read data captured from synchroniser while select is still low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rdata_q <= 1'b0;
    end else begin
      rsp_valid_q <= strobe_done && !write_q;
      if (strobe_done && !write_q) begin
        rdata_q <= dout_sync_q;
      end
    end
  end

  // Ready only in idle; dropped as soon as a request is taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_d == ASR_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign word_address = addr_q;
  assign din = wdata_q;
  assign sel_n = sel_n_q;
  assign we_n = we_n_q;
  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
endmodule : asr_host

// ===== rtl/asr_defs.svh
/*
  Timing constants for the static-memory host controller.
  Assumes a 125 MHz ref_clk (8 ns period) and the slowest speed grade.
*/
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and pin timing, nanoseconds as printed
// ----------------------------------------------------------------------
`define ASR_CLK_NS 8
`define ASR_ADDR_ACCESS_NS 35
`define ASR_WE_PULSE_NS 30
`define ASR_SEL_PULSE_NS 32
`define ASR_ADDR_VALID_NS 30
`define ASR_DATA_SETUP_NS 15
`define ASR_FLOAT_NS 13
`define ASR_RESUME_NS 5

// ----------------------------------------------------------------------
// Derived cycle counts, least times rounded up
// ----------------------------------------------------------------------
`define ASR_CYC_UP(ns) (((ns) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_RD_CYC (`ASR_CYC_UP(`ASR_ADDR_ACCESS_NS) + 1)
`define ASR_WR_CYC `ASR_CYC_UP(`ASR_SEL_PULSE_NS)
`define ASR_FLOAT_CYC `ASR_CYC_UP(`ASR_FLOAT_NS)

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define ASR_ADDR_W 14

`endif

// ===== rtl/asr_pkg.sv
/*
  Types shared by the static-memory host controller.
  Assumes asr_defs.svh supplies the numeric constants.
*/
package asr_pkg;
  // Gray-coded sequence: idle, strobe, hold, recover
  typedef enum logic [1:0] {
    ASR_IDLE = 2'b00,
    ASR_STROBE = 2'b01,
    ASR_HOLD = 2'b11,
    ASR_RECOVER = 2'b10
  } asr_state_t;
endpackage : asr_pkg

// ===== rtl/asr_cnt_if.sv
/*
  Interface between the sequencer and its cycle timer.
  Assumes both ends share ref_clk.
*/
`timescale 1ns/1ps
interface asr_cnt_if;
  logic load;
  logic [3:0] value;
  logic done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface : asr_cnt_if

// ===== rtl/asr_timer.sv
/*
  Down-counting cycle timer: load a count, done rises when it is spent.
  Assumes a single ref_clk domain and active-low asynchronous reset.
*/
`timescale 1ns/1ps
module asr_timer (
  input wire logic ref_clk,
  input wire logic rst_n,
  asr_cnt_if.tmr cnt
);
  logic [3:0] cnt_q;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Done looks at the count only; gating it with load would loop back
  // through the sequencer's own load decode
  assign cnt.done = (cnt_q == 4'h0);

  // Load wins over the running count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (cnt.load) begin
      cnt_q <= cnt.value;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : asr_timer

// ===== testbench/asr_host_properties.sv
/* Pin timing checker for asr_host.
   Assumes binding onto asr_host ports. */
`timescale 1ns/1ps
module asr_host_properties #(
  parameter int ADDR_W = 14
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rsp_valid,
  input wire logic [ADDR_W-1:0] word_address,
  input wire logic sel_n,
  input wire logic we_n,
  input wire logic din
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Write: both low 4 cycles (32 ns), then both high
  sequence wr_low_s;
    (!we_n && !sel_n)[*4] ##1 (we_n && sel_n);
  endsequence
  // Read: select low 7 cycles, then answer
  sequence rd_low_s;
    (!sel_n && we_n)[*7] ##1 (sel_n && rsp_valid);
  endsequence
  wr_start_a: assert property ($fell(we_n) |-> $fell(sel_n) && $stable(word_address))
    else $error("write start bad");
  wr_pulse_a: assert property ($fell(we_n) |-> wr_low_s)
    else $error("write pulse bad");
  addr_hold_a: assert property (!sel_n |=> $stable(word_address))
    else $error("address moved");
  addr_gate_a: assert property ($changed(word_address) |-> sel_n && we_n)
    else $error("address change while active");
  din_hold_a: assert property (!we_n |-> $stable(din))
    else $error("data moved in write");
  wr_end_a: assert property ($rose(we_n) |-> $stable(din) && $stable(word_address))
    else $error("no hold at write end");
  rd_strobe_a: assert property ($fell(sel_n) && we_n |-> rd_low_s)
    else $error("read strobe bad");
  rsp_src_a: assert property (rsp_valid |-> $rose(sel_n) && $past(we_n))
    else $error("answer without read");
endmodule : asr_host_properties
bind asr_host asr_host_properties #(.ADDR_W(ADDR_W)) u_asr_host_properties (
  .ref_clk(ref_clk), .rst_n(rst_n), .rsp_valid(rsp_valid),
  .word_address(word_address), .sel_n(sel_n), .we_n(we_n), .din(din));

// ===== testbench/asr_sram_model.sv
/* Behavioural 16K x 1 static memory.
   Assumes ns units and slowest-grade figures. */
`timescale 1ns/1ps
module asr_sram_model (
  input wire logic [13:0] word_address,
  input wire logic sel_n,
  input wire logic we_n,
  input wire logic din,
  output logic dout
);
  logic mem [0:16383];
  initial dout = 1'b0;
  // Stored while both lows coincide, last value wins
  always @* if (!sel_n && !we_n) mem[word_address] = din;
  // Old data 5 ns, then junk; never a kind stale value
  always @(word_address, sel_n, we_n) begin
    dout <= #5 ~dout;
    if (!sel_n && we_n) dout <= #35 mem[word_address];
  end
endmodule : asr_sram_model

// ===== testbench/tb.sv
/* Self-checking bench for asr_host.
   Assumes the memory model on the pins. */
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_wdata = 1'b0;
  logic [13:0] req_addr = 14'h0000;
  logic req_ready, rsp_valid, rsp_rdata, sel_n, we_n, din, dout;
  logic [13:0] word_address, a;
  logic sh [0:16383];
  logic exp_q [$];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 30667;
  asr_host u_asr_host (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .word_address(word_address), .sel_n(sel_n), .we_n(we_n), .din(din), .dout(dout));
  asr_sram_model u_asr_sram_model (.word_address(word_address), .sel_n(sel_n),
    .we_n(we_n), .din(din), .dout(dout));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask : chk
  task automatic complete_run;
    if (num_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // Request held until taken; valid stays up between calls
  task automatic req(input logic w, input logic [13:0] ad, input logic d);
    int n;
    n = 0;
    req_valid = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    if (w) sh[ad] = d;
    else exp_q.push_back(sh[ad]);
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 60) begin
      n++;
      @(negedge ref_clk);
    end
    if (n == 60) begin
      num_errors++;
      complete_run();
    end
    @(posedge ref_clk);
    #1;
  endtask : req
  // Answers matched to oldest note; negedge avoids edge races
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("spare answer", 1'b0, 1'b1);
      else chk("read bit", exp_q.pop_front(), rsp_rdata);
    end
  end
  initial begin
    #100000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    chk("idle select", 1'b1, sel_n);
    chk("idle strobe", 1'b1, we_n);
    req(1'b1, 14'h0000, 1'b1);
    req(1'b1, 14'h3fff, 1'b0);
    req(1'b0, 14'h0000, 1'b0);
    req(1'b0, 14'h3fff, 1'b0);
    // Random places, each written, read, overwritten with the inverse, read again
    for (int i = 0; i < 12; i++) begin
      a = 14'($random(seed));
      req(1'b1, a, 1'($random(seed)));
      req(1'b0, a, 1'b0);
      req(1'b1, a, ~sh[a]);
      req(1'b0, a, 1'b0);
    end
    req_valid = 1'b0;
    repeat (20) @(posedge ref_clk);
    chk("idle select end", 1'b1, sel_n);
    chk("reads unanswered", 1'b0, exp_q.size() != 0);
    complete_run();
  end
endmodule : tb
